// >>> shared/duflg_cfg.svh
/*
 Register offsets, status bit positions, reset values and buffer sizes
 for the two-channel serial status block.
 Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef DUFLG_CFG_SVH
`define DUFLG_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DUFLG_ADDR_DATA_CH0 32'h01f800e0
`define DUFLG_ADDR_DATA_CH1 32'h01f800e4
`define DUFLG_ADDR_STATUS 32'h01f800e8

// ----------------------------------------
// Status bit positions, channel 0 base
// ----------------------------------------
`define DUFLG_CH_STRIDE 16
`define DUFLG_BIT_RX_READY 0
`define DUFLG_BIT_TX_SHIFT_EMPTY 1
`define DUFLG_BIT_TX_HOLD_EMPTY 2
`define DUFLG_BIT_FRAME_ERR 4
`define DUFLG_BIT_PARITY_ERR 5
`define DUFLG_BIT_OVERRUN_ERR 6
`define DUFLG_BIT_CHAN_CLEAR 7

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define DUFLG_RX_BYTE_RESET 8'h00
`define DUFLG_BYTE_WIDTH 8
`define DUFLG_FIFO_DEPTH 8

`endif

// >>> shared/duflg_pkg.sv
/*
 Types shared by the two-channel serial status block.
 Assumes duflg_cfg.svh is on the include path.
*/
`include "duflg_cfg.svh"

package duflg_pkg;
   typedef logic [`DUFLG_BYTE_WIDTH-1:0] duflg_byte_type;
   typedef logic [31:0] duflg_word_type;
endpackage

// >>> src/duflg_fifo.sv
/*
 Synchronous FIFO with parameter width and depth, valid/ready both sides.
 Assumes one clock, active-low asynchronous reset, depth a power of two.
*/
`timescale 1ns/1ps

module duflg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rd_ptr_r];

   always_ff @(posedge clock) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// >>> src/duflg_top.sv
/*
 Status flags, data registers and transmit buffering for two serial
 channels, reached over a simple register read/write port.
 Assumes the framing engines run on the same clock and give one-cycle
 receive strobes; all register accesses are whole 32-bit words.
*/
`timescale 1ns/1ps
`include "duflg_cfg.svh"

module duflg_top
   import duflg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [31:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output duflg_word_type reg_rdata,
   input wire logic rx_strobe_ch0,
   input wire logic rx_strobe_ch1,
   input wire logic [7:0] rx_data_ch0,
   input wire logic [7:0] rx_data_ch1,
   input wire logic rx_frame_bad_ch0,
   input wire logic rx_frame_bad_ch1,
   input wire logic rx_parity_bad_ch0,
   input wire logic rx_parity_bad_ch1,
   input wire logic tx_idle_ch0,
   input wire logic tx_idle_ch1,
   output duflg_byte_type tx_byte_ch0,
   output duflg_byte_type tx_byte_ch1,
   output logic tx_load_ch0,
   output logic tx_load_ch1,
   output logic chan_reset_ch0,
   output logic chan_reset_ch1
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic [2:0] addr_hit(input logic [31:0] a);
      addr_hit = {a == `DUFLG_ADDR_STATUS, a == `DUFLG_ADDR_DATA_CH1,
                  a == `DUFLG_ADDR_DATA_CH0};
   endfunction

   wire [2:0] hit = addr_hit(reg_addr);
   wire status_wr = reg_wr && hit[2];

   // Per-channel views of the ports
   wire [1:0] rx_strobe = {rx_strobe_ch1, rx_strobe_ch0};
   wire [7:0] rx_data [2];
   wire [1:0] rx_frame_bad = {rx_frame_bad_ch1, rx_frame_bad_ch0};
   wire [1:0] rx_parity_bad = {rx_parity_bad_ch1, rx_parity_bad_ch0};
   wire [1:0] tx_idle = {tx_idle_ch1, tx_idle_ch0};
   assign rx_data[0] = rx_data_ch0;
   assign rx_data[1] = rx_data_ch1;

   duflg_byte_type rx_byte_r [2];
   duflg_byte_type tx_byte_r [2];
   logic [1:0] rx_ready_r;
   logic [1:0] frame_err_r;
   logic [1:0] parity_err_r;
   logic [1:0] overrun_err_r;
   logic [1:0] tx_load_r;
   logic [1:0] chan_clear_r;
   logic [1:0] hold_empty;
   logic [1:0] shift_empty;
   logic [15:0] chan_status [2];

   // ----------------------------------------
   // Channel logic
   // ----------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         wire data_rd = reg_rd && hit[ch];
         wire data_wr = reg_wr && hit[ch];
         wire clear_req = status_wr &&
            reg_wdata[ch*`DUFLG_CH_STRIDE + `DUFLG_BIT_CHAN_CLEAR];
         wire fifo_ready;
         wire fifo_valid;
         wire [7:0] fifo_data;
         wire take = fifo_valid && tx_idle[ch] && !tx_load_r[ch];

         // transmit queue, holding empty clears when the queue is full
         duflg_fifo #(
            .WIDTH(`DUFLG_BYTE_WIDTH),
            .DEPTH(`DUFLG_FIFO_DEPTH)
         ) u_tx_fifo (
            .clock(clock),
            .rst_b(rst_b),
            .flush(clear_req),
            .in_valid(data_wr),
            .in_ready(fifo_ready),
            .in_data(reg_wdata[7:0]),
            .out_valid(fifo_valid),
            .out_ready(take),
            .out_data(fifo_data)
         );

         assign hold_empty[ch] = fifo_ready;
         assign shift_empty[ch] = tx_idle[ch] && !tx_load_r[ch] &&
                                  !fifo_valid;
         assign chan_status[ch] = {8'h00, 1'b0, overrun_err_r[ch],
            parity_err_r[ch], frame_err_r[ch], 1'b0, hold_empty[ch],
            shift_empty[ch], rx_ready_r[ch]};

         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               rx_byte_r[ch] <= `DUFLG_RX_BYTE_RESET;
               tx_byte_r[ch] <= 8'h00;
               rx_ready_r[ch] <= 1'b0;
               frame_err_r[ch] <= 1'b0;
               parity_err_r[ch] <= 1'b0;
               overrun_err_r[ch] <= 1'b0;
               tx_load_r[ch] <= 1'b0;
               chan_clear_r[ch] <= 1'b0;
            end else if (clear_req) begin
               rx_ready_r[ch] <= 1'b0;
               frame_err_r[ch] <= 1'b0;
               parity_err_r[ch] <= 1'b0;
               overrun_err_r[ch] <= 1'b0;
               tx_load_r[ch] <= 1'b0;
               chan_clear_r[ch] <= 1'b1;
            end else begin
               chan_clear_r[ch] <= 1'b0;
               tx_load_r[ch] <= take;
               if (take) begin
                  tx_byte_r[ch] <= fifo_data;
               end
               if (rx_strobe[ch]) begin
                  rx_byte_r[ch] <= rx_data[ch];
               end
               // ready set wins over read clear
               rx_ready_r[ch] <= rx_strobe[ch] ||
                                 (rx_ready_r[ch] && !data_rd);
               if (rx_strobe[ch] && rx_frame_bad[ch]) begin
                  frame_err_r[ch] <= 1'b1;
               end
               if (rx_strobe[ch] && rx_parity_bad[ch]) begin
                  parity_err_r[ch] <= 1'b1;
               end
               if (rx_strobe[ch] && rx_ready_r[ch] && !data_rd) begin
                  overrun_err_r[ch] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // upper bits read zero
   wire [31:0] rd_mux = hit[0] ? {24'h000000, rx_byte_r[0]} :
                        hit[1] ? {24'h000000, rx_byte_r[1]} :
                        hit[2] ? {chan_status[1], chan_status[0]} :
                        32'h00000000;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   assign tx_byte_ch0 = tx_byte_r[0];
   assign tx_byte_ch1 = tx_byte_r[1];
   assign tx_load_ch0 = tx_load_r[0];
   assign tx_load_ch1 = tx_load_r[1];
   assign chan_reset_ch0 = chan_clear_r[0];
   assign chan_reset_ch1 = chan_clear_r[1];
endmodule

// >>> sim/duflg_tx_peer.sv
/* Transmit serializer model for one channel.
 Assumes the block's clock and reset; stall keeps it busy. */
`timescale 1ns/1ps
module duflg_tx_peer (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic stall,
   input wire logic tx_load,
   input wire logic [7:0] tx_byte,
   output logic tx_idle,
   output logic [7:0] last_byte,
   output int sent
);
   logic [2:0] busy_r;
   assign tx_idle = busy_r == 3'h0 && !stall;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 3'h0;
         last_byte <= 8'h00;
         sent <= 0;
      end else if (tx_load) begin
         busy_r <= 3'h5;
         last_byte <= tx_byte;
         sent <= sent + 1;
      end else if (busy_r != 3'h0) begin
         busy_r <= busy_r - 3'h1;
      end
   end
endmodule

// >>> sim/duflg_top_assertions.sv
/* Port checker for the status block.
 Assumes it is bound into duflg_top. */
`timescale 1ns/1ps
`include "duflg_cfg.svh"
module duflg_top_assertions
   import duflg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [31:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire duflg_word_type reg_rdata,
   input wire logic rx_strobe_ch0,
   input wire logic rx_frame_bad_ch0,
   input wire logic tx_load_ch0,
   input wire logic chan_reset_ch0,
   input wire logic chan_reset_ch1
);
   localparam logic [31:0] ST = `DUFLG_ADDR_STATUS;
   wire rd_st = reg_rd && reg_addr == ST;
   wire wr_st = reg_wr && reg_addr == ST;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_bad_rx;
      rx_strobe_ch0 && rx_frame_bad_ch0 && !reg_wr ##1 rd_st && !reg_wr;
   endsequence
   AST_CLR0: assert property (wr_st && reg_wdata[7] |=> chan_reset_ch0)
      else $error("ch0 clear missing");
   AST_CLR1: assert property (wr_st && reg_wdata[23] |=> chan_reset_ch1)
      else $error("ch1 clear missing");
   AST_CLR_SRC: assert property (!(wr_st && reg_wdata[7]) |=> !chan_reset_ch0)
      else $error("stray clear");
   AST_LOAD0: assert property (tx_load_ch0 |=> !tx_load_ch0)
      else $error("load too long");
   AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("rdata moved");
   AST_ST_ZERO: assert property (rd_st |=> (reg_rdata & 32'hff88ff88) == 32'h0)
      else $error("status zero bits");
   AST_UPPER: assert property (reg_rd && !rd_st |=> reg_rdata[31:8] == 24'h0)
      else $error("data upper bits");
   AST_FRAME: assert property (s_bad_rx |=> reg_rdata[4])
      else $error("frame flag missing");
endmodule
bind duflg_top duflg_top_assertions u_chk (.clock, .rst_b, .reg_addr, .reg_rd,
   .reg_wr, .reg_wdata, .reg_rdata, .rx_strobe_ch0, .rx_frame_bad_ch0,
   .tx_load_ch0, .chan_reset_ch0, .chan_reset_ch1);

// >>> sim/test_duflg_top.sv
/* Register-level bench for the status block.
 Assumes serializer models on both channels. */
`timescale 1ns/1ps
`include "duflg_cfg.svh"
module test_duflg_top import duflg_pkg::*;;
   localparam logic [31:0] S = `DUFLG_ADDR_STATUS;
   localparam logic [31:0] D0 = `DUFLG_ADDR_DATA_CH0;
   localparam logic [31:0] D1 = `DUFLG_ADDR_DATA_CH1;
   logic clock = 1'b0, rst_b = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
   logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0;
   logic [1:0] stb = 2'h0, fb = 2'h0, pb = 2'h0, stall = 2'h0;
   logic [7:0] rxd = 8'h00, last0, last1;
   duflg_word_type reg_rdata;
   duflg_byte_type tb0, tb1;
   logic ld0, ld1, idle0, idle1;
   int sent0, sent1, mismatches = 0, cmp_count = 0;
   duflg_top dut (.clock, .rst_b, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata, .rx_strobe_ch0(stb[0]), .rx_strobe_ch1(stb[1]),
      .rx_data_ch0(rxd), .rx_data_ch1(rxd), .rx_frame_bad_ch0(fb[0]),
      .rx_frame_bad_ch1(fb[1]), .rx_parity_bad_ch0(pb[0]),
      .rx_parity_bad_ch1(pb[1]), .tx_idle_ch0(idle0), .tx_idle_ch1(idle1),
      .tx_byte_ch0(tb0), .tx_byte_ch1(tb1), .tx_load_ch0(ld0),
      .tx_load_ch1(ld1), .chan_reset_ch0(), .chan_reset_ch1());
   duflg_tx_peer p0 (.clock, .rst_b, .stall(stall[0]), .tx_load(ld0),
      .tx_byte(tb0), .tx_idle(idle0), .last_byte(last0), .sent(sent0));
   duflg_tx_peer p1 (.clock, .rst_b, .stall(stall[1]), .tx_load(ld1),
      .tx_byte(tb1), .tx_idle(idle1), .last_byte(last1), .sent(sent1));
   initial begin
      forever #25 clock = ~clock;
   end
   task complete_run;
      $display("Checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 1'b0;
      @(negedge clock);
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clock);
      reg_rd = 1'b0;
      chk("rdata", e, reg_rdata);
      @(negedge clock);
   endtask
   task rx(input int c, input logic [7:0] d, input logic f, input logic p);
      stb[c] = 1'b1;
      rxd = d;
      fb[c] = f;
      pb[c] = p;
      @(negedge clock);
      stb = 2'h0;
      fb = 2'h0;
      pb = 2'h0;
   endtask
   task wtx(input int n);
      int i;
      for (i = 0; i < 300; i++) begin
         @(negedge clock);
         if (sent0 + sent1 == n && idle0 && idle1) break;
      end
      if (i == 300) begin
         mismatches++;
         complete_run;
      end
   endtask
   initial begin
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
      rd(S, 32'h00060006);
      rd(D0, 32'h0);
      rd(D1, 32'h0);
      rd(32'h01f800ec, 32'h0);
      rx(1, 8'h5a, 1'b0, 1'b0);
      rd(S, 32'h00070006);
      rd(D1, 32'h5a);
      rd(S, 32'h00060006);
      rx(0, 8'h11, 1'b1, 1'b1);
      rd(S, 32'h00060037);
      rx(0, 8'h22, 1'b0, 1'b0);
      rd(S, 32'h00060077);
      rd(D0, 32'h22);
      rd(S, 32'h00060076);
      wr(S, 32'h00000080);
      rd(S, 32'h00060006);
      rx(1, 8'h33, 1'b1, 1'b1);
      rd(S, 32'h00370006);
      rx(1, 8'h44, 1'b0, 1'b0);
      rd(S, 32'h00770006);
      rd(D1, 32'h44);
      rd(S, 32'h00760006);
      wr(S, 32'h00800000);
      rd(S, 32'h00060006);
      wr(D1, 32'h3c);
      wtx(1);
      chk("byte1", 32'h3c, {24'h0, last1});
      stall[0] = 1'b1;
      for (int k = 0; k < 9; k++) wr(D0, 32'h10 + 32'(k));
      rd(S, 32'h00060000);
      stall[0] = 1'b0;
      wtx(9);
      chk("byte0", 32'h17, {24'h0, last0});
      rd(S, 32'h00060006);
      complete_run;
   end
endmodule
